// *** rtl/dbpt_pkg.sv ***
package dbpt_pkg;

  // Peripheral addresses
  localparam logic [6:0] PA_DISP_START = 7'h01;
  localparam logic [6:0] PA_ADC_REF    = 7'h02;
  localparam logic [6:0] PA_SER_SHIFT  = 7'h03;
  localparam logic [6:0] PA_HSYNC_CNT  = 7'h04;
  localparam logic [6:0] PA_PWM_CH0    = 7'h05;
  localparam logic [6:0] PA_ROM_PTR    = 7'h40;
  localparam logic [6:0] PA_FINE_DAC   = 7'h41;
  localparam int         PWM_CHANNELS  = 4;

  // Active bit counts
  localparam int DISP_BITS   = 7;
  localparam int ADC_BITS    = 4;
  localparam int SER_BITS    = 8;
  localparam int HSYNC_BITS  = 6;
  localparam int PWM_BITS    = 7;
  localparam int ROM_BITS    = 16;
  localparam int FINE_BITS   = 15;
  localparam int TABLE_BITS  = 8;

  // Instruction timing
  localparam int CLOCK_MHZ       = 25;
  localparam int INSTR_TIME_NS   = 2000;
  localparam int INSTR_CYCLES    = (INSTR_TIME_NS * CLOCK_MHZ) / 1000;

  // Select strobe positions
  localparam int SEL_DISP  = 0;
  localparam int SEL_ADC   = 1;
  localparam int SEL_SER   = 2;
  localparam int SEL_HSYNC = 3;
  localparam int SEL_PWM0  = 4;
  localparam int SEL_ROM   = 8;
  localparam int SEL_FINE  = 9;
  localparam int SEL_COUNT = 10;

  // Instruction opcodes from the sequencer
  typedef enum logic [1:0] {
    DBPT_OP_NONE  = 2'h0,
    DBPT_OP_TABLE = 2'h1,
    DBPT_OP_READ  = 2'h2,
    DBPT_OP_WRITE = 2'h3
  } dbpt_op_t;

  // Instruction request
  typedef struct packed {
    dbpt_op_t   op;
    logic [6:0] paddr;
  } dbpt_req_t;

  // Peripheral register images
  typedef struct packed {
    logic [6:0]  disp_start;
    logic [3:0]  adc_ref;
    logic [7:0]  ser_tx;
    logic [27:0] pwm_duty;
    logic [15:0] rom_ptr;
    logic [14:0] fine_dac;
  } dbpt_regs_t;

endpackage

// *** rtl/dbpt_bridge.sv ***
`timescale 1ns/1ns
module dbpt_bridge #(
  parameter int PWM_CH = dbpt_pkg::PWM_CHANNELS
) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire dbpt_pkg::dbpt_req_t  req,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  output logic                      done,
  input  wire logic [3:0]           nib_wr_data,
  input  wire logic [1:0]           nib_wr_sel,
  input  wire logic                 nib_wr_en,
  output logic [3:0]                transfer_buffer_nib_hi,
  output logic [3:0]                transfer_buffer_nib_2,
  output logic [3:0]                transfer_buffer_nib_1,
  output logic [3:0]                transfer_buffer_nib_lo,
  output logic [15:0]               transfer_buffer,
  output logic [7:0]                rom_addr,
  output logic                      rom_rd,
  input  wire logic [15:0]          rom_data,
  output logic                      stack_claim,
  input  wire logic [7:0]           ser_rx_data,
  output logic                      ser_load,
  input  wire logic [5:0]           hsync_count,
  output dbpt_pkg::dbpt_regs_t      periph_regs,
  output logic [15:0]               rom_pointer_register
);

  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_FETCH = 3'b010,
    ST_HOLD  = 3'b100
  } dbpt_state_t;

  dbpt_state_t                 state_ff;
  dbpt_state_t                 nxt_state;
  logic [7:0]                  hold_cnt_ff;
  dbpt_pkg::dbpt_req_t         req_ff;
  logic [15:0]                 buffer_ff;
  logic [6:0]                  disp_ff;
  logic [3:0]                  adc_ff;
  logic [7:0]                  ser_ff;
  logic [PWM_CH*7-1:0]         pwm_ff;
  logic [15:0]                 rom_ptr_ff;
  logic [14:0]                 fine_ff;
  logic [dbpt_pkg::SEL_COUNT-1:0] sel;
  logic                        is_wide;
  logic                        is_valid_rd;
  logic [15:0]                 rd_data;
  logic                        do_xfer;
  logic                        tbl_xfer;
  logic                        rd_xfer;
  logic                        wr_xfer;

  // Last hold count: accept, fetch and hold cycles add up to one instruction time
  localparam logic [7:0] HOLD_LAST = 8'(dbpt_pkg::INSTR_CYCLES - 3);

  // The single transfer cycle of every instruction
  assign do_xfer = (state_ff == ST_FETCH);

  // Transfer cycle split by instruction kind
  assign tbl_xfer = do_xfer && (req_ff.op == dbpt_pkg::DBPT_OP_TABLE);
  assign rd_xfer  = do_xfer && (req_ff.op == dbpt_pkg::DBPT_OP_READ);
  assign wr_xfer  = do_xfer && (req_ff.op == dbpt_pkg::DBPT_OP_WRITE);

  // One-hot register select from the latched address
  always_comb begin
    sel = '0;
    unique case (req_ff.paddr)
      dbpt_pkg::PA_DISP_START: begin
        sel[dbpt_pkg::SEL_DISP] = 1'b1;
      end
      dbpt_pkg::PA_ADC_REF: begin
        sel[dbpt_pkg::SEL_ADC] = 1'b1;
      end
      dbpt_pkg::PA_SER_SHIFT: begin
        sel[dbpt_pkg::SEL_SER] = 1'b1;
      end
      dbpt_pkg::PA_HSYNC_CNT: begin
        sel[dbpt_pkg::SEL_HSYNC] = 1'b1;
      end
      dbpt_pkg::PA_ROM_PTR: begin
        sel[dbpt_pkg::SEL_ROM] = 1'b1;
      end
      dbpt_pkg::PA_FINE_DAC: begin
        sel[dbpt_pkg::SEL_FINE] = 1'b1;
      end
      // PWM channels sit at consecutive addresses; anything else selects nothing
      default: begin
        for (int i = 0; i < PWM_CH; i++) begin
          if (req_ff.paddr == 7'(dbpt_pkg::PA_PWM_CH0 + i)) begin
            sel[dbpt_pkg::SEL_PWM0 + i] = 1'b1;
          end
        end
      end
    endcase
  end

  // Width of the addressed register picks the transfer size
  assign is_wide = sel[dbpt_pkg::SEL_ROM] | sel[dbpt_pkg::SEL_FINE];
  assign is_valid_rd = |sel;

  // Read mux, inactive bits read as zero
  always_comb begin
    rd_data = 16'h0000;
    if (sel[dbpt_pkg::SEL_DISP]) begin
      rd_data[6:0] = disp_ff;
    end
    if (sel[dbpt_pkg::SEL_ADC]) begin
      rd_data[3:0] = adc_ff;
    end
    // Serial reads return received data, not the outgoing byte
    if (sel[dbpt_pkg::SEL_SER]) begin
      rd_data[7:0] = ser_rx_data;
    end
    if (sel[dbpt_pkg::SEL_HSYNC]) begin
      rd_data[5:0] = hsync_count;
    end
    for (int i = 0; i < PWM_CH; i++) begin
      if (sel[dbpt_pkg::SEL_PWM0 + i]) begin
        rd_data[6:0] = pwm_ff[i*7 +: 7];
      end
    end
    if (sel[dbpt_pkg::SEL_ROM]) begin
      rd_data = rom_ptr_ff;
    end
    if (sel[dbpt_pkg::SEL_FINE]) begin
      rd_data[14:0] = fine_ff;
    end
  end

  // Instruction sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      // Wait for a real instruction
      ST_IDLE: begin
        if (req_valid && req.op != dbpt_pkg::DBPT_OP_NONE) begin
          nxt_state = ST_FETCH;
        end
      end
      // Exactly one transfer cycle, whatever the width
      ST_FETCH: begin
        nxt_state = ST_HOLD;
      end
      // Pad to the fixed instruction length
      ST_HOLD: begin
        if (hold_cnt_ff == HOLD_LAST) begin
          nxt_state = ST_IDLE;
        end
      end
      // Recover from a corrupted state code
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pads each instruction out to the instruction time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hold_cnt_ff <= 8'h00;
    end else if (state_ff == ST_HOLD) begin
      hold_cnt_ff <= hold_cnt_ff + 8'h01;
    end else begin
      hold_cnt_ff <= 8'h00;
    end
  end

  // Latch the request when accepted
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      req_ff <= '0;
    end else if (state_ff == ST_IDLE && req_valid) begin
      req_ff <= req;
    end
  end

  // Data buffer: CPU nibble writes and transfer updates
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      buffer_ff <= 16'h0000;
    end else if (tbl_xfer) begin
      buffer_ff <= rom_data;
    end else if (rd_xfer && is_wide) begin
      buffer_ff <= rd_data;
    end else if (rd_xfer && is_valid_rd) begin
      buffer_ff[7:0] <= rd_data[7:0];
    end else if (rd_xfer) begin
      buffer_ff[7:0] <= 8'h00;
    end else if (nib_wr_en) begin
      buffer_ff[4*(3-nib_wr_sel) +: 4] <= nib_wr_data;
    end
  end

  // Display start: no reset, content held over soft resets
  always_ff @(posedge clock) begin
    if (wr_xfer && sel[dbpt_pkg::SEL_DISP]) begin
      disp_ff <= buffer_ff[6:0];
    end
  end

  // ADC reference: only the low four bits are kept
  always_ff @(posedge clock) begin
    if (wr_xfer && sel[dbpt_pkg::SEL_ADC]) begin
      adc_ff <= buffer_ff[3:0];
    end
  end

  // Outgoing serial byte, all eight bits used
  always_ff @(posedge clock) begin
    if (wr_xfer && sel[dbpt_pkg::SEL_SER]) begin
      ser_ff <= buffer_ff[7:0];
    end
  end

  // Fine converter duty, sixteen-bit transfer with fifteen bits kept
  always_ff @(posedge clock) begin
    if (wr_xfer && sel[dbpt_pkg::SEL_FINE]) begin
      fine_ff <= buffer_ff[14:0];
    end
  end

  // PWM duty channels
  for (genvar g = 0; g < PWM_CH; g++) begin : g_pwm
    always_ff @(posedge clock) begin
      if (wr_xfer && sel[dbpt_pkg::SEL_PWM0 + g]) begin
        pwm_ff[g*7 +: 7] <= buffer_ff[6:0];
      end
    end
  end

  // ROM pointer: written via transfer port only; hsync is read only
  always_ff @(posedge clock) begin
    if (wr_xfer && sel[dbpt_pkg::SEL_ROM]) begin
      rom_ptr_ff <= buffer_ff;
    end
  end

  // Handshake and side outputs
  assign req_ready   = (state_ff == ST_IDLE);
  assign done        = (state_ff == ST_HOLD) && (hold_cnt_ff == HOLD_LAST);
  assign rom_addr    = rom_ptr_ff[dbpt_pkg::TABLE_BITS-1:0];
  assign rom_rd      = tbl_xfer;
  assign stack_claim = (state_ff != ST_IDLE) && req_ff.op == dbpt_pkg::DBPT_OP_TABLE;
  assign ser_load    = wr_xfer && sel[dbpt_pkg::SEL_SER];

  // Buffer as a word and as four nibbles, lowest address holds the top nibble
  assign transfer_buffer        = buffer_ff;
  assign transfer_buffer_nib_hi = buffer_ff[15:12];
  assign transfer_buffer_nib_2  = buffer_ff[11:8];
  assign transfer_buffer_nib_1  = buffer_ff[7:4];
  assign transfer_buffer_nib_lo = buffer_ff[3:0];
  assign rom_pointer_register   = rom_ptr_ff;

  // Register images for the peripherals behind the port
  assign periph_regs.disp_start = disp_ff;
  assign periph_regs.adc_ref    = adc_ff;
  assign periph_regs.ser_tx     = ser_ff;
  assign periph_regs.pwm_duty   = pwm_ff[27:0];
  assign periph_regs.rom_ptr    = rom_ptr_ff;
  assign periph_regs.fine_dac   = fine_ff;

endmodule

// *** verif/dbpt_far_model.sv ***
`timescale 1ns/1ns
// Program memory and serial and counter sources
module dbpt_far_model #(
  parameter logic [7:0] RX_BYTE = 8'h96,
  parameter logic [5:0] HS_CNT  = 6'h2b
) (
  input  wire logic [7:0]  rom_addr,
  input  wire logic        rom_rd,
  output logic      [15:0] rom_data,
  output logic      [7:0]  ser_rx_data,
  output logic      [5:0]  hsync_count
);
  // Word follows the address; inverted outside a fetch so stale data shows
  assign rom_data    = {~rom_addr, rom_addr} ^ {16{~rom_rd}} ^ 16'h0f0f;
  assign ser_rx_data = RX_BYTE;
  assign hsync_count = HS_CNT;
endmodule

// *** verif/dbpt_bridge_sva.sv ***
`timescale 1ns/1ns
module dbpt_bridge_chk (
  input wire logic                clock,
  input wire logic                rst,
  input wire dbpt_pkg::dbpt_req_t req,
  input wire logic                req_valid,
  input wire logic                req_ready,
  input wire logic                done,
  input wire logic [15:0]         transfer_buffer,
  input wire logic [3:0]          transfer_buffer_nib_hi,
  input wire logic [3:0]          transfer_buffer_nib_lo,
  input wire logic [7:0]          rom_addr,
  input wire logic                rom_rd,
  input wire logic [15:0]         rom_data,
  input wire logic                stack_claim,
  input wire logic                ser_load,
  input wire logic [15:0]         rom_pointer_register
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Request taken by the bridge
  wire tk = req_valid && req_ready && req.op != dbpt_pkg::DBPT_OP_NONE;
  property p_len; tk |-> ##49 done; endproperty
  a_len: assert property (p_len) else $error("done not at end of instruction");
  property p_busy; tk |=> !req_ready [*8]; endproperty
  a_busy: assert property (p_busy) else $error("ready during instruction");
  property p_rom; rom_rd |-> rom_addr == rom_pointer_register[7:0]; endproperty
  a_rom: assert property (p_rom) else $error("table address wrong");
  property p_tbl; rom_rd |=> transfer_buffer == $past(rom_data); endproperty
  a_tbl: assert property (p_tbl) else $error("table word not loaded");
  property p_stk; tk && req.op == dbpt_pkg::DBPT_OP_TABLE |=> stack_claim [*8]; endproperty
  a_stk: assert property (p_stk) else $error("stack level not held");
  property p_nib; {transfer_buffer_nib_hi, transfer_buffer_nib_lo} == {transfer_buffer[15:12], transfer_buffer[3:0]};
  endproperty
  a_nib: assert property (p_nib) else $error("nibble order wrong");
  property p_ser; tk && req.op == dbpt_pkg::DBPT_OP_WRITE && req.paddr == dbpt_pkg::PA_SER_SHIFT |=> ser_load;
  endproperty
  a_ser: assert property (p_ser) else $error("serial load missing");
  property p_upr; tk && req.op == dbpt_pkg::DBPT_OP_READ && !req.paddr[6]
    |-> ##2 transfer_buffer[15:8] == $past(transfer_buffer[15:8], 2); endproperty
  a_upr: assert property (p_upr) else $error("byte read changed upper byte");
  c_tbl: cover property (tk && req.op == dbpt_pkg::DBPT_OP_TABLE);
  c_ser: cover property (ser_load);
  c_done: cover property (done ##1 req_ready);
endmodule
bind dbpt_bridge dbpt_bridge_chk dbpt_bridge_chk_i (.clock, .rst, .req, .req_valid, .req_ready, .done,
  .transfer_buffer, .transfer_buffer_nib_hi, .transfer_buffer_nib_lo, .rom_addr, .rom_rd, .rom_data,
  .stack_claim, .ser_load, .rom_pointer_register);

// *** verif/tb.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  localparam logic [7:0] RX = 8'h96;
  localparam logic [5:0] HS = 6'h2b;
  logic                 clock, rst, req_valid, req_ready, done, nib_wr_en, rom_rd, stack_claim, ser_load;
  logic [3:0]           nib_wr_data;
  logic [1:0]           nib_wr_sel;
  logic [15:0]          transfer_buffer, rom_data, rom_pointer_register;
  logic [7:0]           rom_addr, ser_rx_data;
  logic [5:0]           hsync_count;
  dbpt_pkg::dbpt_req_t  req;
  dbpt_pkg::dbpt_regs_t periph_regs, keep;
  int                   n_errors, check_count;
  dbpt_bridge dbpt_bridge_i (.clock, .rst, .req, .req_valid, .req_ready, .done, .nib_wr_data, .nib_wr_sel,
    .nib_wr_en, .transfer_buffer_nib_hi(), .transfer_buffer_nib_2(), .transfer_buffer_nib_1(),
    .transfer_buffer_nib_lo(), .transfer_buffer, .rom_addr, .rom_rd, .rom_data, .stack_claim,
    .ser_rx_data, .ser_load, .hsync_count, .periph_regs, .rom_pointer_register);
  dbpt_far_model #(.RX_BYTE(RX), .HS_CNT(HS)) dbpt_far_model_i (.rom_addr, .rom_rd, .rom_data,
    .ser_rx_data, .hsync_count);
  // Clock of 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Counts, verdict and end of run
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Buffer loaded one nibble per cycle, highest nibble first
  task automatic set_buf(input logic [15:0] v);
    for (int i = 0; i < 4; i++) begin
      @(posedge clock);
      nib_wr_en   <= 1'b1;
      nib_wr_sel  <= 2'(i);
      nib_wr_data <= v[15 - 4 * i -: 4];
    end
    @(posedge clock);
    nib_wr_en <= 1'b0;
  endtask
  // One instruction, then wait for its end
  task automatic run_op(input dbpt_pkg::dbpt_op_t op, input logic [6:0] pa);
    @(posedge clock);
    req       <= '{op: op, paddr: pa};
    req_valid <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    repeat (60) begin
      @(posedge clock);
      #1;
      if (done === 1'b1) break;
    end
    `CHK(done, 1'b1)
    @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [6:0] pa);
    run_op(dbpt_pkg::DBPT_OP_WRITE, pa);
  endtask
  task automatic rd(input logic [6:0] pa);
    run_op(dbpt_pkg::DBPT_OP_READ, pa);
  endtask
  // Pointer written through the port, then a table fetch
  task automatic t_table();
    set_buf(16'hc35a);
    wr(dbpt_pkg::PA_ROM_PTR);
    `CHK(rom_pointer_register, 16'hc35a)
    run_op(dbpt_pkg::DBPT_OP_TABLE, 7'h00);
    `CHK(transfer_buffer, {~8'h5a, 8'h5a} ^ 16'h0f0f)
    $display("test table done");
  endtask
  // Each read-write register: active bits, widths, upper byte kept
  task automatic t_regs();
    logic [6:0]  pa [8] = '{7'h01, 7'h02, 7'h05, 7'h06, 7'h07, 7'h08, 7'h41, 7'h40};
    logic [15:0] mk [8] = '{16'h7f, 16'h0f, 16'h7f, 16'h7f, 16'h7f, 16'h7f, 16'h7fff, 16'hffff};
    for (int i = 0; i < 8; i++) begin
      set_buf(16'hd6b5 ^ 16'(i));
      wr(pa[i]);
      set_buf(16'ha500);
      rd(pa[i]);
      `CHK(transfer_buffer, (mk[i][15:8] != 8'h00) ? ((16'hd6b5 ^ 16'(i)) & mk[i]) : {8'ha5, (8'hb5 ^ 8'(i)) & mk[i][7:0]})
    end
    rd(dbpt_pkg::PA_PWM_CH0);
    `CHK(transfer_buffer, {8'hd6, (8'hb5 ^ 8'h02) & 8'h7f})
    $display("test registers done");
  endtask
  // Read-only and unused places, serial data both ways
  task automatic t_misc();
    set_buf(16'h1234);
    keep = periph_regs;
    wr(dbpt_pkg::PA_HSYNC_CNT);
    wr(7'h20);
    `CHK(periph_regs, keep)
    wr(dbpt_pkg::PA_SER_SHIFT);
    `CHK(periph_regs.ser_tx, 8'h34)
    rd(dbpt_pkg::PA_HSYNC_CNT);
    `CHK(transfer_buffer, {8'h12, 2'h0, HS})
    rd(7'h20);
    `CHK(transfer_buffer, 16'h1200)
    rd(dbpt_pkg::PA_SER_SHIFT);
    `CHK(transfer_buffer, {8'h12, RX})
    $display("test misc done");
  endtask
  // Registers hold across a reset in mid-run
  task automatic t_reset();
    keep = periph_regs;
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    #1;
    `CHK(periph_regs, keep)
    $display("test reset done");
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    nib_wr_en = 1'b0;
    nib_wr_sel = 2'h0;
    nib_wr_data = 4'h0;
    n_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    t_table();
    t_regs();
    t_misc();
    t_reset();
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule
